// [include/pmol_pkg.sv]
// Purpose: shared constants, states and carriers of the power mode / lock control
// Assumes: one clock at 100 MHz, one machine cycle is twelve clocks
// Notes:   register offsets are byte addresses on the plain register port
package pmol_pkg;

	// register port geometry
	localparam int unsigned AW = 8;
	localparam int unsigned DW = 32;

	// register offsets
	localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
	localparam logic [AW-1:0] OFS_STATUS  = 8'h04;
	localparam logic [AW-1:0] OFS_KEY_IDX = 8'h08;
	localparam logic [AW-1:0] OFS_KEY_DAT = 8'h0C;
	localparam logic [AW-1:0] OFS_VFY_IN  = 8'h10;
	localparam logic [AW-1:0] OFS_VFY_OUT = 8'h14;

	// control register fields
	localparam int unsigned CTRL_IDLE    = 0;
	localparam int unsigned CTRL_PDOWN   = 1;
	localparam int unsigned CTRL_CRYPT   = 2;
	localparam int unsigned CTRL_VFY_RST = 3;

	// status register fields
	localparam int unsigned ST_MODE_LO  = 0;
	localparam int unsigned ST_EXT      = 3;
	localparam int unsigned ST_LOCK1    = 4;
	localparam int unsigned ST_LOCK2    = 5;
	localparam int unsigned ST_MISMATCH = 6;
	localparam int unsigned ST_VFY_OFF  = 7;
	localparam int unsigned ST_PROG_OFF = 8;

	// timing: idle exit runs at most two machine cycles of twelve clocks
	localparam int unsigned MC_CLKS      = 12;
	localparam int unsigned IDLE_EXIT_MC = 2;
	localparam int unsigned EXIT_CLKS    = IDLE_EXIT_MC * MC_CLKS;
	localparam int unsigned CNT_W        = $clog2(EXIT_CLKS + 1);

	// encryption key array
	localparam int unsigned KEYS  = 32;
	localparam int unsigned KEY_W = $clog2(KEYS);

	// reset value of the strap latch, used before any hardware reset
	localparam logic EA_LATCH_RST = 1'b1;

	typedef enum logic [2:0] {
		M_RUN       = 3'b000,
		M_IDLE      = 3'b001,
		M_IDLE_EXIT = 3'b010,
		M_PDOWN     = 3'b011,
		M_IN_RESET  = 3'b100,
		M_FLOAT     = 3'b101
	} pmol_mode_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          we;
		logic          re;
	} pmol_bus_t;

	// pin state controls toward the port and strobe drivers
	typedef struct packed {
		logic p0_float;
		logic p2_addr;
		logic ports_hold;
		logic ale_low;
		logic program_fetch_strobe_low;
		logic weak_pull;
		logic osc_run;
	} pmol_pins_t;

	// core controls toward cpu, ram and special function registers
	typedef struct packed {
		logic cpu_halt;
		logic ram_block;
		logic ram_hold;
		logic sfr_hold;
		logic sfr_reset;
	} pmol_core_t;

endpackage

// [logic/pmol_sync.sv]
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are slow levels from outside the clock domain
// Notes:   the first stage feeds only the second stage
module pmol_sync #(
	parameter int unsigned W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pmol_sync_st_t;

	pmol_sync_st_t st_q;
	pmol_sync_st_t st_d;

	// shift the pin through both stages
	always_comb begin
		st_d    = st_q;
		st_d.s1 = i_async;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q <= '{s1: RST, s2: RST};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_sync = st_q.s2;
endmodule

// [logic/pmol_crypt.sv]
// Purpose: key store and encrypted verify output
// Assumes: one code byte per i_code_valid pulse
// Notes:   keys are cleared by system reset only, not by the reset pin
module pmol_crypt
	import pmol_pkg::*;
(
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_key_we,
	input  wire logic [KEY_W-1:0] i_key_idx,
	input  wire logic [7:0]       i_key_data,
	input  wire logic             i_restart,
	input  wire logic             i_enc_en,
	input  wire logic             i_code_valid,
	input  wire logic [7:0]       i_code,
	output logic                  o_out_valid,
	output logic      [7:0]       o_out
);
	typedef struct packed {
		logic [KEYS-1:0][7:0] keys;
		logic [KEY_W-1:0]     idx;
		logic                 vld;
		logic [7:0]           out;
	} pmol_crypt_st_t;

	pmol_crypt_st_t st_q;
	pmol_crypt_st_t st_d;

	// restart wins over a byte in the same cycle; index wraps by width
	always_comb begin
		st_d     = st_q;
		st_d.vld = 1'b0;
		if (i_key_we) begin
			st_d.keys[i_key_idx] = i_key_data;
		end
		if (i_restart) begin
			st_d.idx = '0; // [RULE20]
		end else if (i_code_valid) begin
			st_d.vld = 1'b1;
			st_d.out = i_enc_en ? ~(i_code ^ st_q.keys[st_q.idx]) : i_code; // [RULE16]
			st_d.idx = i_enc_en ? st_q.idx + 1'b1 : st_q.idx; // [RULE16] [RULE20]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_out_valid = st_q.vld;
	assign o_out       = st_q.out;

	property p_xnor;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_code_valid && !i_restart && i_enc_en && !i_key_we)
		|=> (o_out == ~($past(i_code) ^ st_q.keys[$past(st_q.idx)]));
	endproperty
	a_xnor: assert property (p_xnor) else $error("verify byte not xnor of key"); // [RULE16]

	property p_wrap;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_code_valid && !i_restart && i_enc_en && st_q.idx == KEY_W'(KEYS - 1))
		|=> (st_q.idx == '0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("key index did not wrap"); // [RULE20]
endmodule

// [logic/pmol_ctrl.sv]
// Purpose: idle, power down, float test mode, strap latch and program lock control
// Assumes: lock bits come from on-chip fuses in this clock domain;
//          reset pin, strobes and strap come from pins and are synchronised
// Notes:   a machine cycle is twelve clocks; key store lives in pmol_crypt
// Overview of operation
// RULE1 - idle external fetch: p0 floats, p2 addresses
// RULE2 - power down: strobes low, ports hold
// RULE3 - reset ends idle: ram blocked two cycles
// RULE4 - software avoids port write after idle
// RULE5 - power down stops oscillator, halts cpu
// RULE6 - ram and registers kept in power down
// RULE7 - only hardware reset leaves power down
// RULE8 - reset clears registers, keeps ram
// RULE9 - reset source waits supply, oscillator settle
// RULE10 - software matches carry and b7 first
// RULE11 - lock1 latches strap during reset
// RULE12 - strap latch must match pin
// RULE13 - ale low through reset enters float
// RULE14 - float: p0 floats, others weak high
// RULE15 - ordinary reset leaves float mode
// RULE16 - verify bytes xnor with key sequence
// RULE17 - lock1 blocks external reads, programming
// RULE18 - both locks also disable verify
// RULE19 - reserved lock code adds nothing
// RULE20 - key index restarts and wraps
module pmol_ctrl
	import pmol_pkg::*;
(
	input  wire logic                i_clk,
	input  wire logic                i_sys_rst,
	input  wire pmol_pkg::pmol_bus_t i_bus,
	output logic [pmol_pkg::DW-1:0]  o_rdata,
	input  wire logic                i_rst_pin,
	input  wire logic                i_ale_pin,
	input  wire logic                i_program_fetch_strobe_pin,
	input  wire logic                i_ea_n_pin,
	input  wire logic                i_irq,
	input  wire logic                i_lock1_prog,
	input  wire logic                i_lock2_prog,
	output pmol_pkg::pmol_pins_t     o_pins,
	output pmol_pkg::pmol_core_t     o_core,
	output logic                     o_ext_fetch,
	output logic                     o_int_code_block,
	output logic                     o_prog_block
);
	import pmol_pkg::*;

	typedef struct packed {
		pmol_mode_t    mode;
		logic [CNT_W-1:0] cnt;
		logic          once_arm;
		logic          ea_latch;
		logic          crypt_en;
		logic [KEY_W-1:0] key_idx;
		pmol_pins_t    pins;
		pmol_core_t    core;
		logic          ext;
		logic          int_blk;
		logic          prog_blk;
		logic [DW-1:0] rdata;
	} pmol_st_t;

	pmol_st_t st_q;
	pmol_st_t st_d;

	logic [3:0]  sync_out;
	logic        rst_s;
	logic        ale_s;
	logic        program_fetch_strobe_s;
	logic        ea_n_s;
	logic        vfy_vld;
	logic [7:0]  vfy_out;
	logic        lock1;
	logic        vfy_off;
	logic        key_we;
	logic        vfy_rst;
	logic        code_vld;

	// strobes idle high and the reset pin low, so a missing pull does not look like reset
	pmol_sync #(
		.W   (4),
		.RST (4'h6)
	) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_rst_pin, i_ale_pin, i_program_fetch_strobe_pin, i_ea_n_pin}),
		.o_sync    (sync_out)
	);
	assign {rst_s, ale_s, program_fetch_strobe_s, ea_n_s} = sync_out;

	// lock decode; the reserved pattern (lock2 only) decodes as unlocked
	assign lock1   = i_lock1_prog; // [RULE17] [RULE19]
	assign vfy_off = i_lock1_prog & i_lock2_prog; // [RULE18] [RULE19]

	// register strobes toward the key store
	assign key_we   = i_bus.we && (i_bus.addr == OFS_KEY_DAT);
	assign vfy_rst  = i_bus.we && (i_bus.addr == OFS_CTRL) && i_bus.wdata[CTRL_VFY_RST];
	assign code_vld = i_bus.we && (i_bus.addr == OFS_VFY_IN) && !vfy_off; // [RULE18]

	pmol_crypt u_crypt (
		.i_clk        (i_clk),
		.i_sys_rst    (i_sys_rst),
		.i_key_we     (key_we),
		.i_key_idx    (st_q.key_idx),
		.i_key_data   (i_bus.wdata[7:0]),
		.i_restart    (vfy_rst),
		.i_enc_en     (st_q.crypt_en),
		.i_code_valid (code_vld),
		.i_code       (i_bus.wdata[7:0]),
		.o_out_valid  (vfy_vld),
		.o_out        (vfy_out)
	);

	// pin and core controls implied by one mode
	function automatic pmol_pins_t pins_of(input pmol_mode_t m, input logic ext);
		pmol_pins_t p;
		p = '{p0_float: 1'b0, p2_addr: 1'b0, ports_hold: 1'b0, ale_low: 1'b0,
		      program_fetch_strobe_low: 1'b0, weak_pull: 1'b0, osc_run: 1'b1};
		case (m)
			M_IDLE, M_IDLE_EXIT: begin
				p.p0_float   = ext; // [RULE1]
				p.p2_addr    = ext; // [RULE1]
				p.ports_hold = 1'b1; // [RULE1]
			end
			M_PDOWN: begin
				p.ale_low    = 1'b1; // [RULE2]
				p.program_fetch_strobe_low   = 1'b1; // [RULE2]
				p.p0_float   = ext; // [RULE2]
				p.ports_hold = 1'b1; // [RULE2]
				p.osc_run    = 1'b0; // [RULE5]
			end
			M_FLOAT: begin
				p.p0_float  = 1'b1; // [RULE14]
				p.weak_pull = 1'b1; // [RULE14]
			end
			default: begin
				p.osc_run = 1'b1;
			end
		endcase
		return p;
	endfunction

	function automatic pmol_core_t core_of(input pmol_mode_t m);
		pmol_core_t c;
		c = '0;
		case (m)
			M_IDLE:      c.cpu_halt  = 1'b1;
			M_IDLE_EXIT: c.ram_block = 1'b1; // [RULE3] ports stay held
			M_PDOWN: begin
				c.cpu_halt = 1'b1; // [RULE5]
				c.ram_hold = 1'b1; // [RULE6]
				c.sfr_hold = 1'b1; // [RULE6]
			end
			M_IN_RESET:  c.sfr_reset = 1'b1; // [RULE8] ram is never cleared
			M_FLOAT:     c.cpu_halt  = 1'b1;
			default:     c.cpu_halt  = 1'b0;
		endcase
		return c;
	endfunction

	// mode sequencing, register writes and read data
	always_comb begin
		st_d       = st_q;
		st_d.rdata = '0;
		st_d.cnt   = '0;
		case (st_q.mode)
			M_RUN: begin
				if (rst_s) begin
					st_d.mode = M_IN_RESET;
				end else if (i_bus.we && i_bus.addr == OFS_CTRL && i_bus.wdata[CTRL_PDOWN]) begin
					st_d.mode = M_PDOWN; // [RULE5] halts right after this write
				end else if (i_bus.we && i_bus.addr == OFS_CTRL && i_bus.wdata[CTRL_IDLE]) begin
					st_d.mode = M_IDLE;
				end
			end
			M_IDLE: begin
				if (rst_s) begin
					st_d.mode = M_IDLE_EXIT; // [RULE3]
				end else if (i_irq) begin
					st_d.mode = M_RUN;
				end
			end
			M_IDLE_EXIT: begin
				// execution may run on briefly; ram is fenced off and ports are held
				st_d.cnt = st_q.cnt + 1'b1;
				if (st_q.cnt == CNT_W'(EXIT_CLKS - 1)) begin
					st_d.mode = M_IN_RESET; // [RULE3]
				end
			end
			M_PDOWN: begin
				// interrupts are ignored; the reset source must wait for supply
				if (rst_s) begin
					st_d.mode = M_IN_RESET; // [RULE7] [RULE9]
				end
			end
			M_IN_RESET: begin
				if (lock1) begin
					st_d.ea_latch = ea_n_s; // [RULE11] [RULE12]
				end
				st_d.once_arm = st_q.once_arm ? !ale_s : (!ale_s && program_fetch_strobe_s); // [RULE13]
				if (!rst_s) begin
					st_d.mode     = (st_q.once_arm && !ale_s) ? M_FLOAT : M_RUN; // [RULE13]
					st_d.once_arm = 1'b0;
				end
			end
			M_FLOAT: begin
				if (rst_s) begin
					st_d.mode = M_IN_RESET; // [RULE15]
				end
			end
			default: begin
				st_d.mode = M_IN_RESET;
			end
		endcase
		if (i_bus.we && i_bus.addr == OFS_CTRL) begin
			st_d.crypt_en = i_bus.wdata[CTRL_CRYPT];
		end
		if (i_bus.we && i_bus.addr == OFS_KEY_IDX) begin
			st_d.key_idx = i_bus.wdata[KEY_W-1:0];
		end
		if (i_bus.re) begin
			case (i_bus.addr)
				OFS_CTRL:    st_d.rdata[CTRL_CRYPT] = st_q.crypt_en;
				OFS_STATUS: begin
					st_d.rdata[ST_MODE_LO +: 3] = st_q.mode;
					st_d.rdata[ST_EXT]          = st_q.ext;
					st_d.rdata[ST_LOCK1]        = i_lock1_prog;
					st_d.rdata[ST_LOCK2]        = i_lock2_prog;
					st_d.rdata[ST_MISMATCH]     = lock1 && (st_q.ea_latch != ea_n_s); // [RULE12]
					st_d.rdata[ST_VFY_OFF]      = vfy_off;
					st_d.rdata[ST_PROG_OFF]     = lock1;
				end
				OFS_KEY_IDX: st_d.rdata[KEY_W-1:0] = st_q.key_idx;
				OFS_VFY_OUT: st_d.rdata[8:0] = {vfy_vld, vfy_out};
				default:     st_d.rdata = '0;
			endcase
		end
		st_d.ext      = lock1 ? ~st_d.ea_latch : ~ea_n_s;
		st_d.pins     = pins_of(st_d.mode, st_d.ext);
		st_d.core     = core_of(st_d.mode);
		st_d.int_blk  = lock1 && st_d.ext; // [RULE17]
		st_d.prog_blk = lock1; // [RULE17]
	end

	// reset clears registers and the key index; the strap latch takes a constant
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q          <= '0;
			st_q.mode     <= M_IN_RESET;
			st_q.ea_latch <= EA_LATCH_RST;
			st_q.pins     <= pins_of(M_IN_RESET, 1'b0);
			st_q.core     <= core_of(M_IN_RESET);
		end else begin
			st_q <= st_d;
		end
	end

	assign o_rdata          = st_q.rdata;
	assign o_pins           = st_q.pins;
	assign o_core           = st_q.core;
	assign o_ext_fetch      = st_q.ext;
	assign o_int_code_block = st_q.int_blk;
	assign o_prog_block     = st_q.prog_blk;

	property p_idle_pins;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_IDLE && st_q.ext) |-> (o_pins.p0_float && o_pins.p2_addr);
	endproperty
	a_idle_pins: assert property (p_idle_pins) else $error("idle pins wrong"); // [RULE1]

	property p_pd_pins;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_PDOWN) |-> (o_pins.ale_low && o_pins.program_fetch_strobe_low
			&& o_pins.p0_float == st_q.ext && o_pins.ports_hold);
	endproperty
	a_pd_pins: assert property (p_pd_pins) else $error("power down pins wrong"); // [RULE2]

	sequence s_exit_run;
		(st_q.mode == M_IDLE_EXIT && o_core.ram_block)[*8];
	endsequence
	property p_idle_exit;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_IDLE && rst_s) |=> s_exit_run ##17 (st_q.mode == M_IN_RESET);
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle exit timing wrong"); // [RULE3]

	property p_pd_osc;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_RUN && !rst_s && i_bus.we && i_bus.addr == OFS_CTRL
			&& i_bus.wdata[CTRL_PDOWN]) |=> (!o_pins.osc_run && o_core.cpu_halt);
	endproperty
	a_pd_osc: assert property (p_pd_osc) else $error("oscillator not stopped"); // [RULE5]

	property p_pd_hold;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_PDOWN) |-> (o_core.ram_hold && o_core.sfr_hold && !o_core.sfr_reset);
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("state not held"); // [RULE6]

	property p_pd_stay;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_PDOWN && !rst_s) |=> (st_q.mode == M_PDOWN);
	endproperty
	a_pd_stay: assert property (p_pd_stay) else $error("power down left without reset"); // [RULE7]

	property p_reset_regs;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_PDOWN && rst_s) |=> (o_core.sfr_reset && !o_core.ram_hold);
	endproperty
	a_reset_regs: assert property (p_reset_regs) else $error("reset did not clear regs"); // [RULE8]

	property p_ea_latch;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_IN_RESET && lock1) |=> (st_q.ea_latch == $past(ea_n_s));
	endproperty
	a_ea_latch: assert property (p_ea_latch) else $error("strap not latched"); // [RULE11]

	property p_float_pins;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_FLOAT) |-> (o_pins.p0_float && o_pins.weak_pull && o_pins.osc_run);
	endproperty
	a_float_pins: assert property (p_float_pins) else $error("float pins wrong"); // [RULE14]

	property p_float_exit;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q.mode == M_FLOAT && rst_s) |=> (st_q.mode == M_IN_RESET);
	endproperty
	a_float_exit: assert property (p_float_exit) else $error("float not left on reset"); // [RULE15]

	property p_locks;
		@(posedge i_clk) disable iff (i_sys_rst)
		1'b1 |=> (o_prog_block == $past(i_lock1_prog)
			&& o_int_code_block == ($past(i_lock1_prog) && o_ext_fetch));
	endproperty
	a_locks: assert property (p_locks) else $error("lock decode wrong"); // [RULE17] [RULE19]

	property p_vfy_off;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_lock1_prog && i_lock2_prog) |=> !vfy_vld;
	endproperty
	a_vfy_off: assert property (p_vfy_off) else $error("verify not disabled"); // [RULE18]
endmodule

// [sim/pmol_far_model.sv]
// Purpose: far side model: reset circuit, strap and emulator pins
// Assumes: strap follows the bench's choice of external fetch
// Notes:   strobe pins idle high, like the weak pull-ups they stand for
module pmol_far_model #(
	parameter int unsigned OSC_SETTLE = 40
) (
	input  wire logic i_clk,
	input  wire logic i_ext_mode,
	output logic      o_rst_pin,
	output logic      o_ale_pin,
	output logic      o_program_fetch_strobe_pin,
	output logic      o_ea_n_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// pins at rest: reset low, strobes pulled high
	initial begin
		o_rst_pin = 1'b0;
		o_ale_pin = 1'b1;
		o_program_fetch_strobe_pin = 1'b1;
	end

	// strap follows ext_mode at once, even when the bench moves it without a reset
	always_comb o_ea_n_pin = ~i_ext_mode;

	// reset pulse; long enough for a stopped oscillator to settle
	task automatic hw_reset(input bit once);
		@(posedge i_clk);
		o_rst_pin <= 1'b1;
		if (once) begin
			o_ale_pin <= 1'b0; // ale low in reset while program_fetch_strobe stays high
		end
		repeat (OSC_SETTLE) @(posedge i_clk);
		o_rst_pin <= 1'b0;
		repeat (6) @(posedge i_clk); // ale held low across release
		o_ale_pin <= 1'b1;
	endtask
endmodule

// [sim/pmol_ctrl_tb.sv]
// Purpose: self-checking bench of the power mode and lock control
// Assumes: register port as in the package, one clock of 10 ns
// Notes:   lock and strap cases run from a table, modes by hand
module pmol_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pmol_pkg::*;

	logic          i_clk;
	logic          i_sys_rst;
	logic          i_irq;
	logic          i_lock1_prog;
	logic          i_lock2_prog;
	logic          ext_mode;
	logic          rst_pin;
	logic          ale_pin;
	logic          program_fetch_strobe_pin;
	logic          ea_n_pin;
	logic          o_ext_fetch;
	logic          o_int_code_block;
	logic          o_prog_block;
	logic [DW-1:0] o_rdata;
	logic [DW-1:0] d;
	pmol_bus_t     bus;
	pmol_pins_t    o_pins;
	pmol_core_t    o_core;
	int            mismatches;
	int            total_checks;
	int            n;
	// rows: lock1, lock2, strap_n, ext, int block, prog block, status[8:3]
	logic [11:0]   rows [6] = '{12'h200, 12'h9E3, 12'hDF7, 12'h505, 12'hA62, 12'h101};

	pmol_ctrl pmol_ctrl_inst (
		.i_clk           (i_clk),
		.i_sys_rst       (i_sys_rst),
		.i_bus           (bus),
		.o_rdata         (o_rdata),
		.i_rst_pin       (rst_pin),
		.i_ale_pin       (ale_pin),
		.i_program_fetch_strobe_pin      (program_fetch_strobe_pin),
		.i_ea_n_pin      (ea_n_pin),
		.i_irq           (i_irq),
		.i_lock1_prog    (i_lock1_prog),
		.i_lock2_prog    (i_lock2_prog),
		.o_pins          (o_pins),
		.o_core          (o_core),
		.o_ext_fetch     (o_ext_fetch),
		.o_int_code_block(o_int_code_block),
		.o_prog_block    (o_prog_block)
	);

	pmol_far_model pmol_far_model_inst (
		.i_clk     (i_clk),
		.i_ext_mode(ext_mode),
		.o_rst_pin (rst_pin),
		.o_ale_pin (ale_pin),
		.o_program_fetch_strobe_pin(program_fetch_strobe_pin),
		.o_ea_n_pin(ea_n_pin)
	);

	// free running 100 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic tally_and_finish();
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// strobes last one cycle; every bus task starts on the next rising edge
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge i_clk);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge i_clk);
		bus <= '0;
	endtask

	// data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge i_clk);
		bus <= '{a, '0, 1'b0, 1'b1};
		@(posedge i_clk);
		bus <= '0;
		@(negedge i_clk);
		v = o_rdata;
	endtask

	// code byte in, result read back with no gap so the valid flag shows
	task automatic vfy(input logic [7:0] code, output logic [DW-1:0] v);
		@(posedge i_clk);
		bus <= '{OFS_VFY_IN, {24'h000000, code}, 1'b1, 1'b0};
		@(posedge i_clk);
		bus <= '{OFS_VFY_OUT, '0, 1'b0, 1'b1};
		@(posedge i_clk);
		bus <= '0;
		@(negedge i_clk);
		v = o_rdata;
	endtask

	// bounded poll of the mode field
	task automatic wait_mode(input logic [2:0] m);
		logic [DW-1:0] s;
		for (int i = 0; i < 30; i++) begin
			rd(OFS_STATUS, s);
			if (s[2:0] === m) return;
		end
		mismatches++;
		$display("BAD mode_wait expected %h seen %h", m, s[2:0]);
		tally_and_finish();
	endtask

	// main sequence
	initial begin
		bus = '0;
		i_sys_rst = 1'b1;
		i_irq = 1'b0;
		i_lock1_prog = 1'b0;
		i_lock2_prog = 1'b0;
		ext_mode = 1'b0;
		mismatches = 0;
		total_checks = 0;
		repeat (12) @(posedge i_clk);
		@(negedge i_clk);
		chk("rst_sfr", o_core.sfr_reset, 1);
		chk("rst_osc", o_pins.osc_run, 1);
		@(posedge i_clk);
		i_sys_rst <= 1'b0;
		wait_mode(M_RUN);
		// lock and strap table, each row through a hardware reset
		for (int r = 0; r < 6; r++) begin
			@(posedge i_clk);
			i_lock1_prog <= rows[r][11];
			i_lock2_prog <= rows[r][10];
			ext_mode <= ~rows[r][9];
			pmol_far_model_inst.hw_reset(1'b0);
			wait_mode(M_RUN);
			rd(OFS_STATUS, d);
			chk("status", d[8:3], rows[r][5:0]);
			chk("ext", o_ext_fetch, rows[r][8]);
			chk("int_block", o_int_code_block, rows[r][7]);
			chk("prog_block", o_prog_block, rows[r][6]);
		end
		// idle from external memory, left by an interrupt
		wr(OFS_CTRL, 32'h0000_0001);
		wait_mode(M_IDLE);
		chk("idle_p0", o_pins.p0_float, 1);
		chk("idle_p2", o_pins.p2_addr, 1);
		chk("idle_hold", o_pins.ports_hold, 1);
		@(posedge i_clk);
		i_irq <= 1'b1;
		wait_mode(M_RUN);
		@(posedge i_clk);
		i_irq <= 1'b0;
		// idle ended by reset; only status reads follow the request
		wr(OFS_CTRL, 32'h0000_0001);
		wait_mode(M_IDLE);
		fork
			pmol_far_model_inst.hw_reset(1'b0);
			begin
				for (n = 0; n < 20 && o_core.ram_block !== 1'b1; n++) @(negedge i_clk);
				for (n = 0; n < 40 && o_core.ram_block === 1'b1; n++) @(negedge i_clk);
				chk("exit_len", n, EXIT_CLKS);
				chk("exit_sfr", o_core.sfr_reset, 1);
			end
		join
		wait_mode(M_RUN);
		// power down from external then internal memory
		for (int e = 1; e >= 0; e--) begin
			@(posedge i_clk);
			ext_mode <= e[0];
			wr(OFS_CTRL, 32'h0000_0002); // carry and b7 are software's concern
			wait_mode(M_PDOWN);
			chk("pd_ale", o_pins.ale_low, 1);
			chk("pd_program_fetch_strobe", o_pins.program_fetch_strobe_low, 1);
			chk("pd_p0", o_pins.p0_float, e);
			chk("pd_hold", o_pins.ports_hold, 1);
			chk("pd_osc", o_pins.osc_run, 0);
			chk("pd_halt", o_core.cpu_halt, 1);
			chk("pd_keep", {o_core.ram_hold, o_core.sfr_hold}, 2'h3);
			@(posedge i_clk);
			i_irq <= 1'b1;
			wr(OFS_CTRL, 32'h0000_0001);
			rd(OFS_STATUS, d);
			chk("pd_stays", d[2:0], M_PDOWN);
			@(posedge i_clk);
			i_irq <= 1'b0;
			fork
				pmol_far_model_inst.hw_reset(1'b0);
				begin
					wait_mode(M_IN_RESET);
					chk("pd_sfr", o_core.sfr_reset, 1);
					chk("pd_ram", o_core.ram_block, 0);
				end
			join
			wait_mode(M_RUN);
		end
		// float test mode in and out
		pmol_far_model_inst.hw_reset(1'b1);
		wait_mode(M_FLOAT);
		chk("fl_p0", o_pins.p0_float, 1);
		chk("fl_pull", o_pins.weak_pull, 1);
		chk("fl_osc", o_pins.osc_run, 1);
		pmol_far_model_inst.hw_reset(1'b0);
		wait_mode(M_RUN);
		chk("fl_off", o_pins.weak_pull, 0);
		// encrypted verify with key wrap and restart
		wr(OFS_KEY_IDX, 32'h0000_0000);
		wr(OFS_KEY_DAT, 32'h0000_003C);
		wr(OFS_KEY_IDX, 32'h0000_001F);
		wr(OFS_KEY_DAT, 32'h0000_00A5);
		wr(OFS_CTRL, 32'h0000_000C);
		vfy(8'h96, d);
		chk("vfy_k0", d[8:0], {1'b1, ~(8'h96 ^ 8'h3C)});
		// keys 1 to 30 stay zero, so the verify index walks to key 31 by bytes
		for (int k = 1; k < KEYS - 1; k++) begin
			vfy(8'h0F, d);
			chk("vfy_mid", d[8:0], 9'h1F0);
		end
		vfy(8'hF0, d);
		chk("vfy_k31", d[8:0], {1'b1, ~(8'hF0 ^ 8'hA5)});
		vfy(8'h00, d);
		chk("vfy_wrap", d[8:0], {1'b1, ~(8'h00 ^ 8'h3C)});
		vfy(8'h5A, d);
		chk("idx_next", d[8:0], 9'h1A5);
		// key store pointer is separate from the verify index
		rd(OFS_KEY_IDX, d);
		chk("idx_reg", d[4:0], 5'h1F);
		wr(OFS_CTRL, 32'h0000_000C);
		vfy(8'h96, d);
		chk("idx_restart", d[8:0], {1'b1, ~(8'h96 ^ 8'h3C)});
		wr(OFS_CTRL, 32'h0000_0008);
		vfy(8'h96, d);
		chk("vfy_plain", d[8:0], 9'h196);
		@(posedge i_clk);
		i_lock1_prog <= 1'b1;
		i_lock2_prog <= 1'b1;
		vfy(8'h11, d);
		chk("vfy_locked", d[8], 0);
		// strap moved without a reset: latch keeps internal fetch, status flags it
		@(posedge i_clk);
		ext_mode <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(OFS_STATUS, d);
		chk("strap_flag", d[ST_MISMATCH], 1);
		chk("strap_kept", o_ext_fetch, 0);
		rd(8'h40, d);
		chk("unmapped", d, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
